// file: pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; output changes only when stages two and three agree.
module pin_sync
(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] stage_reg;

	// Shift chain; reset to the idle-high pin level.
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			stage_reg <= 3'h7;
		else
			stage_reg <= {stage_reg[1:0], pin_i};
	end

	// Accept a new level only once the later stages agree.
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			level_o <= 1'b1;
		else if (stage_reg[1] == stage_reg[2])
			level_o <= stage_reg[2];
	end
endmodule

// file: reset_cause_pkg.sv
package reset_cause_pkg;

	// Program counter width for a 4K-word program memory.
	localparam int PC_W = 12;
	localparam logic [11:0] RESET_VECTOR = 12'h000;
	localparam logic [11:0] IRQ_VECTOR = 12'h008;
	localparam logic [11:0] RESERVED_BASE = 12'hffb;
	localparam logic [11:0] RESERVED_TOP = 12'hfff;

	// Flag register layout and default.
	localparam int PD_N_BIT = 2;
	localparam int TO_N_BIT = 3;
	localparam logic [7:0] FLAG_RESET = 8'h00;

	// Hold count after a reset source drops, in cycles.
	localparam int RESET_HOLD = 4;
	localparam int SYNC_STAGES = 3;

	// Cause codes for the two flags.
	typedef struct packed
	{
		logic timeout_n_flag;
		logic power_down_n_flag;
	} cause_t;

	localparam cause_t CAUSE_POR = '{timeout_n_flag: 1'b1, power_down_n_flag: 1'b0};
	localparam cause_t CAUSE_WDT = '{timeout_n_flag: 1'b0, power_down_n_flag: 1'b0};
	localparam cause_t CAUSE_EXT = '{timeout_n_flag: 1'b1, power_down_n_flag: 1'b1};

	// Program counter control from the core.
	typedef struct packed
	{
		logic       advance;
		logic       jump;
		logic [11:0] target;
	} pc_ctl_t;

endpackage

// file: reset_partner.sv
`timescale 1ns/1ps
// Far side: the reset pin circuit and the watchdog that feed the block.
module reset_partner
(
	input  wire logic mclk_i,
	input  wire logic pin_low_i,
	input  wire logic wdt_fire_i,
	output logic      ext_reset_n_o = 1'b1,
	output logic      wdt_overflow_o = 1'b0
);
	// pin idles high
	// Pin stays high unless a reset is asked for; the overflow follows wdt_fire_i one cycle late.
	always @(posedge mclk_i)
	begin
		ext_reset_n_o <= !pin_low_i;
		wdt_overflow_o <= wdt_fire_i;
	end
endmodule

// file: reset_vector_and_cause_logic.sv
`timescale 1ns/1ps
module reset_vector_and_cause_logic
#(
	parameter int HOLD = reset_cause_pkg::RESET_HOLD
)
(
	input  wire logic                   mclk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ext_reset_n_i,
	input  wire logic                   wdt_overflow_i,
	input  wire logic                   irq_take_i,
	input  wire reset_cause_pkg::pc_ctl_t pc_ctl_i,
	input  wire logic                   flag_wr_i,
	input  wire logic [7:0]             flag_wdata_i,
	output logic                        sys_reset_o,
	output logic [11:0]                 pc_o,
	output logic                        push_o,
	output logic [11:0]                 push_data_o,
	output logic [7:0]                  processor_flag_reg_o,
	output logic                        pc_reserved_o
);
	logic                 pin_level;
	logic                 src_active;
	logic [2:0]           hold_reg;
	logic                 por_seen_reg;
	reset_cause_pkg::cause_t cause_reg;
	logic [11:0]          pc_reg;
	logic [5:0]           flag_low_reg;
	logic                 push_reg;
	logic [11:0]          push_data_reg;

	pin_sync u_pin_sync
	(
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.pin_i   (ext_reset_n_i),
		.level_o (pin_level)
	);

	// A source is active while the pin is low or on a watchdog overflow pulse.
	// pin holds reset
	assign src_active = !pin_level || wdt_overflow_i;

	// Stretch the internal reset so the core sees a clean multi-cycle pulse.
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			hold_reg <= 3'(HOLD);
		else if (src_active)
			hold_reg <= 3'(HOLD);
		else if (hold_reg != 3'h0)
			hold_reg <= hold_reg - 3'h1;
	end

	// The core stays in reset while the stretch counter runs, so a one-cycle watchdog pulse still gives a full restart.
	assign sys_reset_o = (hold_reg != 3'h0);

	// Record the cause; power-on is the asynchronous reset itself.
	// cause encoding
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			cause_reg <= reset_cause_pkg::CAUSE_POR;
		else if (wdt_overflow_i)
			cause_reg <= reset_cause_pkg::CAUSE_WDT;
		else if (!pin_level)
			cause_reg <= reset_cause_pkg::CAUSE_EXT;
	end

	// Program counter: reset vector wins over everything else.
	// restart at zero
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			pc_reg <= reset_cause_pkg::RESET_VECTOR;
		else if (sys_reset_o || src_active)
			pc_reg <= reset_cause_pkg::RESET_VECTOR;
		else if (irq_take_i)
			pc_reg <= reset_cause_pkg::IRQ_VECTOR;
		else if (pc_ctl_i.jump)
			pc_reg <= pc_ctl_i.target;
		else if (pc_ctl_i.advance)
			pc_reg <= pc_reg + 12'h001;
	end

	// Stack push of the return address on interrupt entry.
	// push current pc
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			push_reg      <= 1'b0;
			push_data_reg <= 12'h000;
		end
		else
		begin
			push_reg      <= irq_take_i && !sys_reset_o && !src_active;
			push_data_reg <= pc_reg;
		end
	end

	// Software-writable flag bits; cause bits are read-only to software.
	// registers defaulted
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			flag_low_reg <= 6'h00;
		else if (sys_reset_o || src_active)
			flag_low_reg <= 6'h00;
		else if (flag_wr_i)
			flag_low_reg <= {flag_wdata_i[7:4], flag_wdata_i[1:0]};
	end

	assign processor_flag_reg_o = {flag_low_reg[5:2], cause_reg.timeout_n_flag,
		cause_reg.power_down_n_flag, flag_low_reg[1:0]};

	// Outputs come straight from registers, so the core never sees a glitch on them.
	assign pc_o        = pc_reg;
	assign push_o      = push_reg;
	assign push_data_o = push_data_reg;

	assign pc_reserved_o = (pc_reg >= reset_cause_pkg::RESERVED_BASE);

	property p_pc_zero;
		@(posedge mclk_i) disable iff (rst_i)
		sys_reset_o |=> (pc_o == 12'h000);
	endproperty
	a_pc_zero: assert property (p_pc_zero) else $error("pc not zero during reset");

	property p_flags_default;
		@(posedge mclk_i) disable iff (rst_i)
		$fell(sys_reset_o) |-> ({processor_flag_reg_o[7:4], processor_flag_reg_o[1:0]} == 6'h00);
	endproperty
	a_flags_default: assert property (p_flags_default) else $error("flags not defaulted");

	property p_wdt_cause;
		@(posedge mclk_i) disable iff (rst_i)
		wdt_overflow_i |=> (processor_flag_reg_o[3:2] == 2'h0);
	endproperty
	a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog cause wrong");

	property p_ext_cause;
		@(posedge mclk_i) disable iff (rst_i)
		(!pin_level && !wdt_overflow_i) |=> (processor_flag_reg_o[3:2] == 2'h3);
	endproperty
	a_ext_cause: assert property (p_ext_cause) else $error("external cause wrong");

	sequence s_wdt;
		wdt_overflow_i;
	endsequence
	property p_wdt_reset;
		@(posedge mclk_i) disable iff (rst_i)
		s_wdt |=> sys_reset_o [*2];
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog gave no reset");

	property p_pin_hold;
		@(posedge mclk_i) disable iff (rst_i)
		!pin_level |=> sys_reset_o;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin low without reset");

	property p_irq_vec;
		@(posedge mclk_i) disable iff (rst_i)
		(irq_take_i && !sys_reset_o && !src_active) |=> (pc_o == 12'h008) && push_o;
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector wrong");

	property p_reserved;
		@(posedge mclk_i) disable iff (rst_i)
		(pc_o < 12'hffb) |-> !pc_reserved_o;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved flag wrong");

	property p_push_data;
		@(posedge mclk_i) disable iff (rst_i)
		(irq_take_i && !sys_reset_o && !src_active) |=> (push_data_o == $past(pc_o));
	endproperty
	a_push_data: assert property (p_push_data) else $error("pushed address wrong");

	property p_wdt_pc;
		@(posedge mclk_i) disable iff (rst_i)
		s_wdt |=> (pc_o == reset_cause_pkg::RESET_VECTOR);
	endproperty
	a_wdt_pc: assert property (p_wdt_pc) else $error("watchdog did not restart fetch");

	property p_reserved_top;
		@(posedge mclk_i) disable iff (rst_i)
		(pc_o >= reset_cause_pkg::RESERVED_BASE) |-> pc_reserved_o;
	endproperty
	a_reserved_top: assert property (p_reserved_top) else $error("reserved address not flagged");

	property p_write_refused;
		@(posedge mclk_i) disable iff (rst_i)
		(sys_reset_o && flag_wr_i) |=> ({processor_flag_reg_o[7:4], processor_flag_reg_o[1:0]} == 6'h00);
	endproperty
	a_write_refused: assert property (p_write_refused) else $error("flag write during reset");
endmodule

// file: reset_vector_and_cause_logic_tb.sv
`timescale 1ns/1ps
module reset_vector_and_cause_logic_tb;
	logic                     mclk_i = 1'b0;
	logic                     rst_i = 1'b1;
	logic                     pin_low = 1'b0;
	logic                     wdt_fire = 1'b0;
	logic                     irq_take = 1'b0;
	logic                     flag_wr = 1'b0;
	logic [7:0]               flag_wdata = 8'h00;
	reset_cause_pkg::pc_ctl_t pc_ctl = '0;
	logic                     ext_n;
	logic                     wdt_ov;
	logic                     sys_reset;
	logic                     push;
	logic                     reserved;
	logic [7:0]               flags;
	logic [11:0]              pc;
	logic [11:0]              push_data;
	int                       n_errors = 0;
	int                       checks_done = 0;

	// Free-running 4 ns clock.
	always #2 mclk_i = ~mclk_i;

	reset_partner far (.mclk_i(mclk_i), .pin_low_i(pin_low), .wdt_fire_i(wdt_fire),
		.ext_reset_n_o(ext_n), .wdt_overflow_o(wdt_ov));
	reset_vector_and_cause_logic dut (.mclk_i(mclk_i), .rst_i(rst_i), .ext_reset_n_i(ext_n),
		.wdt_overflow_i(wdt_ov), .irq_take_i(irq_take), .pc_ctl_i(pc_ctl), .flag_wr_i(flag_wr),
		.flag_wdata_i(flag_wdata), .sys_reset_o(sys_reset), .pc_o(pc), .push_o(push),
		.push_data_o(push_data), .processor_flag_reg_o(flags), .pc_reserved_o(reserved));

	task chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bounded wait for the internal reset to drop, then confirm it did.
	task wait_run;
		for (int i = 0; i < 40 && sys_reset !== 1'b0; i++)
		begin
			@(posedge mclk_i);
			#1;
		end
		chk(12'(sys_reset), 12'h000);
	endtask

	task conclude;
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task t_por;
		@(posedge mclk_i);
		#1;
		chk(12'(sys_reset), 12'h001);
		chk(pc, 12'h000);
		chk(12'(flags), 12'h008);
		@(posedge mclk_i);
		rst_i <= 1'b0;
		wait_run();
		chk(12'(flags), 12'h008);
	endtask

	// Three advances then an interrupt: pc 3 is pushed and fetch goes to 008.
	task t_irq;
		@(posedge mclk_i);
		pc_ctl <= '{advance: 1'b1, jump: 1'b0, target: 12'h000};
		repeat (3) @(posedge mclk_i);
		pc_ctl <= '0;
		irq_take <= 1'b1;
		@(posedge mclk_i);
		irq_take <= 1'b0;
		#1;
		chk(12'(push), 12'h001);
		chk(push_data, 12'h003);
		chk(pc, 12'h008);
	endtask

	task t_resv;
		logic [11:0] tgt [3];
		tgt = '{12'hffa, 12'hffb, 12'hfff};
		foreach (tgt[i])
		begin
			@(posedge mclk_i);
			pc_ctl <= '{advance: 1'b0, jump: 1'b1, target: tgt[i]};
			@(posedge mclk_i);
			pc_ctl <= '0;
			#1;
			chk(pc, tgt[i]);
			chk(12'(reserved), 12'(tgt[i] >= 12'hffb));
		end
	endtask

	// Dirty the flag register, then let the watchdog reset clean it.
	task t_wdt;
		@(posedge mclk_i);
		flag_wr <= 1'b1;
		flag_wdata <= 8'hf3;
		@(posedge mclk_i);
		flag_wr <= 1'b0;
		#1;
		chk(12'(flags), 12'h0fb);
		@(posedge mclk_i);
		wdt_fire <= 1'b1;
		@(posedge mclk_i);
		wdt_fire <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
		chk(12'(sys_reset), 12'h001);
		wait_run();
		chk(pc, 12'h000);
		chk(12'(flags), 12'h000);
	endtask

	// Pin held low with the core pushing advances and flag writes; once the
	// synchronised pin takes hold, nothing may move and writes are refused.
	task t_ext;
		@(posedge mclk_i);
		pin_low <= 1'b1;
		pc_ctl <= '{advance: 1'b1, jump: 1'b0, target: 12'h000};
		flag_wr <= 1'b1;
		flag_wdata <= 8'hf3;
		repeat (10) @(posedge mclk_i);
		#1;
		chk(12'(sys_reset), 12'h001);
		chk(pc, 12'h000);
		@(posedge mclk_i);
		pin_low <= 1'b0;
		pc_ctl <= '0;
		flag_wr <= 1'b0;
		wait_run();
		chk(pc, 12'h000);
		chk(12'(flags), 12'h00c);
	endtask

	initial
	begin
		t_por();
		t_irq();
		t_resv();
		t_wdt();
		t_ext();
		conclude();
	end

	// The tests need well under a hundred cycles; the 5000-cycle limit means a hang.
	initial
	begin
		#20000;
		n_errors++;
		conclude();
	end
endmodule
